// File: core/feel_norm.sv
// normaliser: unsigned magnitude and exponent offset to extended real
`timescale 1ns/1ns
`default_nettype none
module feel_norm (
    input wire logic sign,
    input wire logic [63:0] mag,
    input wire logic [15:0] adj,
    output logic [79:0] val
);
    import feel_pkg::*;
    logic [5:0] pos;
    logic [63:0] sh;
    logic [15:0] ex;
    always_comb begin
        pos = 6'h00;
        for (int k = 0; k < 64; k++) begin
            if (mag[k]) pos = 6'(k);
        end
        sh = mag << (6'h3F - pos);
        ex = {1'b0, EXP_BIAS} + {10'h000, pos} + adj;
        // exponent overflow is not trapped; results stay in range for
        // the operand spans this unit is fed
        val = (mag == 64'h0) ? {sign, 79'h0} : {sign, ex[14:0], sh};
    end
endmodule
`default_nettype wire

// File: core/feel_pkg.sv
// constants, types and decode helpers of the fpu stack operation unit
// Notes on behaviour
// RQ1: exchange swaps stack top with stack register i, taking four clocks.
// RQ2: exchange without explicit operand uses stack register one.
// RQ3: these ops set condition bit one by convention; bits zero, two, three untouched.
// RQ4: emulation or task-switched control bit set traps the op before it runs.
// RQ5: extract splits stack top into exponent and significand in 19 clocks.
// RQ6: extract writes exponent into stack top, pushes, then writes held significand.
// RQ7: new stack top keeps sign and significand, biased exponent forced to 3FFF.
// RQ8: stack register one holds the operand's unbiased exponent as extended real.
// RQ9: zero operand gives minus infinity exponent, signed zero, and zero-divide.
// RQ10: extract raises invalid operation unless stack register seven is empty.
// RQ11: log multiplies register one by log2 of top, stores there, pops; 311 clocks.
// RQ12: log raises invalid operation when the stack top operand is negative.
// RQ13: log may flag precision, underflow, overflow, zero-divide, denormal, invalid, stack; the code never flags underflow or overflow.
// RQ14: long log ops sample pending interrupts periodically and abort to serve them.
// RQ15: log-plus-one does the same with log2 of top plus one; 313 clocks.
// RQ16: software keeps the log-plus-one operand within its range; else undefined.
// RQ17: stack-top pointer is three bits wrapping modulo eight.
package feel_pkg;
    localparam int EXT_W = 80;
    localparam int SIGN_BIT = 79;
    localparam int EXP_HI = 78;
    localparam int EXP_LO = 64;
    localparam logic [14:0] EXP_BIAS = 15'h3FFF;
    localparam logic [79:0] NEG_INF = {1'b1, 15'h7FFF, 64'h8000000000000000};
    localparam logic [15:0] LOG_ADJ = 16'h002F;
    localparam logic [15:0] XF_SHIFT = 16'h002F;
    localparam logic [31:0] LOG2E_Q16 = 32'h00017154;
    // opcodes: first byte in cmd[15:8], second in cmd[7:0]
    localparam logic [7:0] OP_ESC = 8'hD9;
    localparam logic [7:0] OP_XCH_BASE = 8'hC8;
    localparam logic [7:0] OP_XCH_MASK = 8'hF8;
    localparam logic [7:0] OP_XTR = 8'hF4;
    localparam logic [7:0] OP_LOG = 8'hF1;
    localparam logic [7:0] OP_LOGP1 = 8'hF9;
    // instruction lengths in core clocks
    localparam logic [8:0] XCH_CLKS = 9'h004;
    localparam logic [8:0] XTR_CLKS = 9'h013;
    localparam logic [8:0] LOG_CLKS = 9'h137;
    localparam logic [8:0] LOGP1_CLKS = 9'h139;
    localparam logic [8:0] SAMPLE_MASK = 9'h00F;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] REG_SEL = 8'h14;
    localparam logic [7:0] REG_DATA0 = 8'h18;
    localparam logic [7:0] REG_DATA1 = 8'h1C;
    localparam logic [7:0] REG_DATA2 = 8'h20;
    localparam logic [7:0] REG_TAG = 8'h24;
    localparam int CTRL_EM = 0;
    localparam int CTRL_TS = 1;
    localparam int CTRL_REAL = 2;
    localparam int EX_P = 0;
    localparam int EX_U = 1;
    localparam int EX_O = 2;
    localparam int EX_Z = 3;
    localparam int EX_D = 4;
    localparam int EX_I = 5;
    localparam int EX_IS = 6;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_EXC = 2;
    localparam int IRQ_ABORT = 3;
    localparam logic [7:0] FAULT_VEC = 8'h07;

    typedef enum logic [4:0] {
        K_NONE = 5'h01, K_XCH = 5'h02, K_XTR = 5'h04,
        K_LOG = 5'h08, K_LOGP1 = 5'h10
    } feel_kind_t;
    typedef enum logic [1:0] {S_IDLE = 2'h1, S_RUN = 2'h2} feel_state_t;

    function automatic feel_kind_t op_kind(input logic [15:0] cmd);
        op_kind = K_NONE;
        if (cmd[15:8] == OP_ESC) begin
            if ((cmd[7:0] & OP_XCH_MASK) == OP_XCH_BASE) op_kind = K_XCH;
            else if (cmd[7:0] == OP_XTR) op_kind = K_XTR;
            else if (cmd[7:0] == OP_LOG) op_kind = K_LOG;
            else if (cmd[7:0] == OP_LOGP1) op_kind = K_LOGP1;
        end
    endfunction

    function automatic logic [8:0] op_clks(input feel_kind_t k);
        case (k)
            K_XCH: op_clks = XCH_CLKS;
            K_XTR: op_clks = XTR_CLKS;
            K_LOG: op_clks = LOG_CLKS;
            K_LOGP1: op_clks = LOGP1_CLKS;
            default: op_clks = XCH_CLKS;
        endcase
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] sel);
        be_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) be_merge[b*8 +: 8] = nw[b*8 +: 8];
        end
    endfunction
endpackage

// File: core/feel_unit.sv
// fpu register stack with exchange, extract and scaled log operations
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module feel_unit (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic intr_pending,
    output logic irq
);
    import feel_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [15:0] cmd_q;
    logic [2:0] sel_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [6:0] exc_q;
    logic [3:0] cond_q;
    logic fault_rm_q;
    logic [2:0] top_q;
    logic [7:0] empty_q;
    logic [79:0] stk_q [8];
    feel_state_t state_q;
    feel_kind_t kind_q;
    logic [8:0] cnt_q;
    logic ack_q;
    logic [31:0] dat_q;

    logic acc, wr;
    logic [31:0] rdata, wm;
    feel_kind_t kind_new;
    logic launch_try, launch, fault_now;
    logic fin, abort, fin_ok;
    logic [2:0] p0, p1, pi, p7, ps;
    logic [79:0] st0, st1, st_i, stw, normv;
    logic xs, xzero, xden;
    logic [14:0] xe;
    logic [63:0] xm, xf, p2, prod, nmag;
    logic [15:0] etrue, eabs, shamt, nadj;
    logic [31:0] v, vm, vmag;
    logic vneg, nsign;
    logic [6:0] exc_d;
    logic c1_d, wok;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign acc = wb_cyc & wb_stb & ~ack_q;
    assign wr = acc & wb_we;
    assign wb_ack = ack_q;
    assign wb_dat_r = dat_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    assign p0 = top_q; // RQ17
    assign p1 = top_q + 3'h1; // RQ17
    assign p7 = top_q - 3'h1; // RQ17
    assign pi = top_q + cmd_q[2:0]; // RQ2
    assign ps = top_q + sel_q;
    assign st0 = stk_q[p0];
    assign st1 = stk_q[p1];
    assign st_i = stk_q[pi];
    assign stw = stk_q[ps];

    always_comb begin
        case (wb_adr)
            REG_CTRL: rdata = {29'h0, ctrl_q};
            REG_CMD: rdata = {16'h0, cmd_q};
            REG_STAT: rdata = {7'h0, fault_rm_q, FAULT_VEC, 1'b0, exc_q,
                cond_q, top_q, state_q == S_RUN};
            REG_IRQ_STAT: rdata = {28'h0, irq_stat_q};
            REG_IRQ_MASK: rdata = {28'h0, irq_mask_q};
            REG_SEL: rdata = {29'h0, sel_q};
            REG_DATA0: rdata = stw[31:0];
            REG_DATA1: rdata = stw[63:32];
            REG_DATA2: rdata = {16'h0, stw[79:64]};
            REG_TAG: rdata = {24'h0, empty_q};
            default: rdata = 32'h0;
        endcase
    end
    assign wm = be_merge(rdata, wb_dat_w, wb_sel);

    assign kind_new = op_kind(wm[15:0]);
    assign launch_try = wr & (wb_adr == REG_CMD) & (state_q == S_IDLE);
    assign fault_now = launch_try & (kind_new != K_NONE)
        & (ctrl_q[CTRL_EM] | ctrl_q[CTRL_TS]); // RQ4
    assign launch = launch_try & (kind_new != K_NONE) & ~fault_now;

    assign fin = (state_q == S_RUN) & (cnt_q == 9'h000);
    // the check point recurs every sixteen clocks; an abort discards
    // the whole operation, so the stack is left as it was
    assign abort = (state_q == S_RUN) & ((kind_q == K_LOG)
        | (kind_q == K_LOGP1)) & ((cnt_q & SAMPLE_MASK) == 9'h000)
        & intr_pending; // RQ14
    assign fin_ok = fin & ~abort;

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    assign xs = st0[SIGN_BIT];
    assign xe = st0[EXP_HI:EXP_LO];
    assign xm = st0[63:0];
    assign xzero = (xe == 15'h0) & (xm == 64'h0);
    assign xden = (xe == 15'h0) & (xm != 64'h0);
    assign etrue = {1'b0, xe} - {1'b0, EXP_BIAS}; // RQ8
    assign eabs = etrue[15] ? 16'(-etrue) : etrue;
    assign shamt = XF_SHIFT - etrue;
    assign xf = (shamt[15] | (shamt > 16'h003F)) ? 64'h0 : xm >> shamt[5:0];
    assign p2 = xf[31:0] * LOG2E_Q16;
    assign vm = p2[47:16];
    // log2 is a first-order estimate: exponent plus linear fraction,
    // and x times log2(e) near one; cheap, precision flag set on every written result
    assign v = (kind_q == K_LOG) ? {etrue, xm[62:47]}
        : (xs ? 32'(-vm) : vm); // RQ11 RQ15
    assign vneg = v[31];
    assign vmag = vneg ? 32'(-v) : v;
    assign prod = st1[63:32] * vmag;
    assign nadj = {1'b0, st1[EXP_HI:EXP_LO]} - {1'b0, EXP_BIAS} - LOG_ADJ;

    always_comb begin
        if (kind_q == K_XTR) begin
            nsign = etrue[15]; // RQ8
            nmag = {48'h0, eabs};
        end else begin
            nsign = st1[SIGN_BIT] ^ vneg;
            nmag = prod;
        end
    end

    feel_norm u_norm (
        .sign(nsign),
        .mag(nmag),
        .adj(kind_q == K_XTR ? 16'h0000 : nadj),
        .val(normv)
    );

    // exceptions, condition bit one and write permission at finish
    always_comb begin
        exc_d = 7'h00;
        c1_d = 1'b0; // RQ3
        wok = 1'b0;
        case (kind_q)
            K_XCH: begin
                if (empty_q[p0] | empty_q[pi]) begin
                    exc_d[EX_I] = 1'b1;
                    exc_d[EX_IS] = 1'b1;
                end else begin
                    wok = 1'b1;
                end
            end
            K_XTR: begin
                if (empty_q[p0]) begin
                    exc_d[EX_I] = 1'b1;
                    exc_d[EX_IS] = 1'b1;
                end else if (!empty_q[p7]) begin
                    exc_d[EX_I] = 1'b1; // RQ10
                    exc_d[EX_IS] = 1'b1;
                    c1_d = 1'b1; // RQ3
                end else begin
                    exc_d[EX_Z] = xzero; // RQ9
                    exc_d[EX_D] = xden;
                    wok = 1'b1;
                end
            end
            K_LOG, K_LOGP1: begin
                if (empty_q[p0] | empty_q[p1]) begin
                    exc_d[EX_I] = 1'b1; // RQ13
                    exc_d[EX_IS] = 1'b1;
                end else if (kind_q == K_LOG && xs && !xzero) begin
                    exc_d[EX_I] = 1'b1; // RQ12
                end else if (kind_q == K_LOG && xzero) begin
                    exc_d[EX_Z] = 1'b1; // RQ13
                end else begin
                    exc_d[EX_P] = 1'b1; // RQ13
                    exc_d[EX_D] = xden;
                    wok = 1'b1;
                end
            end
            default: wok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= acc;
            if (acc) dat_q <= rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= 3'h0;
            sel_q <= 3'h0;
            irq_mask_q <= 4'h0;
            cmd_q <= 16'h0;
        end else if (wr) begin
            if (wb_adr == REG_CTRL) ctrl_q <= wm[2:0];
            if (wb_adr == REG_SEL) sel_q <= wm[2:0];
            if (wb_adr == REG_IRQ_MASK) irq_mask_q <= wm[3:0];
            if (launch_try) cmd_q <= wm[15:0];
        end
    end

    // set wins over a simultaneous write-one clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr && wb_adr == REG_IRQ_STAT)
                ? (wb_dat_w[3:0] & {4{wb_sel[0]}}) : 4'h0))
                | {abort, fin_ok & (exc_d != 7'h00), fault_now, fin_ok};
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            kind_q <= K_NONE;
            cnt_q <= 9'h000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (launch) begin
                        state_q <= S_RUN;
                        kind_q <= kind_new;
                        cnt_q <= op_clks(kind_new) - 9'h001; // RQ1 RQ5
                    end
                end
                S_RUN: begin
                    if (fin | abort) state_q <= S_IDLE;
                    else cnt_q <= cnt_q - 9'h001;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            exc_q <= 7'h00;
            cond_q <= 4'h0;
            fault_rm_q <= 1'b0;
        end else begin
            if (fin_ok) begin
                exc_q <= exc_d;
                cond_q[1] <= c1_d; // RQ3
            end
            if (fault_now) fault_rm_q <= ctrl_q[CTRL_REAL]; // RQ4
        end
    end

    // ------------------------------------------------------------
    // register stack
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            top_q <= 3'h0;
            empty_q <= 8'hFF;
            for (int k = 0; k < 8; k++) stk_q[k] <= 80'h0;
        end else if (fin_ok && wok) begin
            case (kind_q)
                K_XCH: begin
                    stk_q[p0] <= st_i; // RQ1
                    stk_q[pi] <= st0; // RQ1
                end
                K_XTR: begin
                    stk_q[p0] <= xzero ? NEG_INF : normv; // RQ6 RQ9
                    stk_q[p7] <= xzero ? {xs, 79'h0}
                        : {xs, EXP_BIAS, xm}; // RQ7
                    empty_q[p7] <= 1'b0;
                    top_q <= p7; // RQ6
                end
                K_LOG, K_LOGP1: begin
                    stk_q[p1] <= normv; // RQ11 RQ15
                    empty_q[p0] <= 1'b1;
                    top_q <= p1; // RQ11
                end
                default: top_q <= top_q;
            endcase
        end else if (wr && state_q == S_IDLE) begin
            // debug window only while idle, so an op sees a still stack
            if (wb_adr == REG_DATA0) stk_q[ps][31:0] <= wm;
            if (wb_adr == REG_DATA1) stk_q[ps][63:32] <= wm;
            if (wb_adr == REG_DATA2) stk_q[ps][79:64] <= wm[15:0];
            if (wb_adr == REG_TAG) empty_q <= wm[7:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [8:0] run_cnt;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) run_cnt <= 9'h000;
        else if (launch) run_cnt <= 9'h000;
        else if (state_q == S_RUN) run_cnt <= run_cnt + 9'h001;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_go(feel_kind_t k);
        launch && kind_new == k;
    endsequence
    sequence s_done(feel_kind_t k);
        fin_ok && wok && kind_q == k;
    endsequence

    a_xch_four_clk: assert property (s_go(K_XCH) |-> ##4 fin) // RQ1
        else $error("exchange did not finish in four clocks");
    a_xch_default: assert property ( // RQ2
        (s_go(K_XCH) and (wm[2:0] == 3'h1)) |-> ##4 (pi == p1))
        else $error("default exchange does not target register one");
    a_xch_swap: assert property (s_done(K_XCH) // RQ1
        |=> stk_q[$past(p0)] == $past(st_i))
        else $error("exchange did not move register i to top");
    a_fault_trap: assert property (fault_now // RQ4
        |=> state_q == S_IDLE && irq_stat_q[IRQ_FAULT])
        else $error("op ran despite emulation or task switch");
    a_xtr_time: assert property (s_go(K_XTR) |-> ##19 fin) // RQ5
        else $error("extract did not finish in 19 clocks");
    a_xtr_bias: assert property ((s_done(K_XTR) and !xzero) // RQ7
        |=> stk_q[top_q][EXP_HI:EXP_LO] == EXP_BIAS
        && top_q == $past(top_q) - 3'h1)
        else $error("extract top lacks bias exponent or push");
    a_xtr_full: assert property (fin && kind_q == K_XTR // RQ10
        && !empty_q[p0] && !empty_q[p7] |=> exc_q[EX_I])
        else $error("extract with full slot seven not invalid");
    a_xtr_zero: assert property ((s_done(K_XTR) and xzero) // RQ9
        |=> exc_q[EX_Z] && stk_q[$past(p0)] == NEG_INF)
        else $error("zero extract lacks minus infinity or zero-divide");
    a_log_time: assert property (fin && kind_q == K_LOG // RQ11
        |-> run_cnt == LOG_CLKS - 9'h001)
        else $error("log did not take 311 clocks");
    a_log_neg: assert property (fin_ok && kind_q == K_LOG && xs // RQ12
        && !xzero && !empty_q[p0] && !empty_q[p1]
        |=> exc_q[EX_I] && $stable(top_q))
        else $error("negative log operand not invalid");
    a_log_pop: assert property ( // RQ15
        (s_done(K_LOG) or s_done(K_LOGP1))
        |=> top_q == $past(top_q) + 3'h1 && empty_q[$past(p0)])
        else $error("log did not pop the stack");
    a_abort_irq: assert property (abort // RQ14
        |=> state_q == S_IDLE && irq_stat_q[IRQ_ABORT]
        && $stable(top_q))
        else $error("interrupt did not abort the log op");
endmodule
`default_nettype wire

// File: sim/feel_pipe_model.sv
// pipeline-side model: raises the pending-interrupt level on request
`timescale 1ns/1ns
`default_nettype none
module feel_pipe_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic fire,
    output logic intr_pending
);
    logic [5:0] hold_q;
    // held for 20 cycles so that a sixteen-cycle sample point is met
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_q <= 6'h00;
        end else if (fire) begin
            hold_q <= 6'h14;
        end else if (hold_q != 6'h00) begin
            hold_q <= hold_q - 6'h01;
        end
    end
    assign intr_pending = (hold_q != 6'h00);
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench of the fpu stack operation unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import feel_pkg::*;
    logic ref_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, irq, fire, intr;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    int err_total = 0;
    int n_checks = 0;
    logic [79:0] one = 80'h3FFF_8000000000000000;
    logic [79:0] two = 80'h4000_8000000000000000;
    logic [79:0] quarter = 80'h3FFD_8000000000000000;
    logic [79:0] xin [3] = '{80'h4003_8000000000000000,
        80'h3FF8_C000000000000000, 80'h8000_0000000000000000};
    logic [79:0] xtop [3] = '{80'h3FFF_8000000000000000,
        80'h3FFF_C000000000000000, 80'h8000_0000000000000000};
    logic [79:0] xexp [3] = '{80'h4001_8000000000000000,
        80'hC001_E000000000000000, NEG_INF};
    logic [6:0] xexc [3] = '{7'h00, 7'h00, 7'h08};
    logic [2:0] cv [3] = '{3'h1, 3'h2, 3'h6};

    feel_unit dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .intr_pending(intr), .irq(irq));
    feel_pipe_model pipe_u (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire),
        .intr_pending(intr));

    // ---------------------------------------------
    // bus cycles
    // ---------------------------------------------
    task automatic xfer(input logic we, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat_w <= d;
        @(posedge ref_clk);
        // only the watchdog ends a wait for the answer
        while (wb_ack !== 1'b1) begin
            @(posedge ref_clk);
        end
        r = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h00000000, r);
    endtask
    task automatic ent_wr(input logic [2:0] s, input logic [79:0] v);
        wr(REG_SEL, {29'h00000000, s});
        wr(REG_DATA0, v[31:0]);
        wr(REG_DATA1, v[63:32]);
        wr(REG_DATA2, {16'h0000, v[79:64]});
    endtask
    task automatic ent_chk(input logic [2:0] s, input logic [79:0] v);
        logic [31:0] a, b, c;
        wr(REG_SEL, {29'h00000000, s});
        rd(REG_DATA0, a);
        rd(REG_DATA1, b);
        rd(REG_DATA2, c);
        `CHK({c[15:0], b, a}, v)
    endtask
    // done must show on irq exactly one edge after the last busy cycle
    task automatic run(input logic [15:0] cmd, input int n);
        wr(REG_CMD, {16'h0000, cmd});
        repeat (n - 3) @(posedge ref_clk);
        #1 `CHK(irq, 1'b0)
        @(posedge ref_clk);
        #1 `CHK(irq, 1'b1)
        @(posedge ref_clk);
        wr(REG_IRQ_STAT, 32'h0000000F);
    endtask
    task automatic restart();
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        wr(REG_IRQ_MASK, 32'h0000000F);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------
    // tests
    // ---------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    initial begin
        {rst_n, wb_cyc, wb_stb, wb_we, fire} = 5'h00;
        {wb_adr, wb_dat_w} = 40'h0000000000;
        wb_sel = 4'hF;
        restart();
        rd(REG_STAT, q);
        `CHK(q[3:0], 4'h0)
        rd(REG_TAG, q);
        `CHK(q[7:0], 8'hFF)
        rd(8'hFC, q);
        `CHK(q, 32'h00000000)
        $display("test reset done");
        ent_wr(3'h0, one);
        ent_wr(3'h1, two);
        wr(REG_TAG, 32'h000000FC);
        run(16'hD9C9, XCH_CLKS);
        ent_chk(3'h0, two);
        ent_chk(3'h1, one);
        rd(REG_STAT, q);
        `CHK({q[14:8], q[5]}, 8'h00)
        run(16'hD9CA, XCH_CLKS);
        rd(REG_STAT, q);
        `CHK(q[14:8], 7'h60)
        ent_chk(3'h0, two);
        $display("test exchange done");
        wr(REG_IRQ_MASK, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            wr(REG_CTRL, {29'h00000000, cv[i]});
            wr(REG_CMD, 32'h0000D9C9);
            rd(REG_IRQ_STAT, q);
            `CHK({q[1], irq}, 2'h2)
            rd(REG_STAT, q);
            `CHK(q[24:16], {cv[i][2], FAULT_VEC})
            wr(REG_IRQ_MASK, 32'h00000002);
            `CHK(irq, 1'b1)
            wr(REG_IRQ_STAT, 32'h00000002);
            `CHK(irq, 1'b0)
            wr(REG_IRQ_MASK, 32'h00000000);
        end
        wr(REG_CTRL, 32'h00000000);
        ent_chk(3'h0, two);
        $display("test fault done");
        for (int i = 0; i < 3; i++) begin
            restart();
            ent_wr(3'h0, xin[i]);
            wr(REG_TAG, 32'h000000FE);
            run(16'hD9F4, XTR_CLKS);
            rd(REG_STAT, q);
            `CHK({q[14:8], q[3:1]}, {xexc[i], 3'h7})
            ent_chk(3'h0, xtop[i]);
            ent_chk(3'h1, xexp[i]);
        end
        restart();
        ent_wr(3'h0, one);
        wr(REG_TAG, 32'h00000000);
        run(16'hD9F4, XTR_CLKS);
        rd(REG_STAT, q);
        `CHK({q[14:8], q[5], q[3:1]}, {7'h60, 1'b1, 3'h0})
        ent_chk(3'h0, one);
        $display("test extract done");
        for (int i = 0; i < 3; i++) begin
            restart();
            ent_wr(3'h0, (i == 2) ? quarter
                : ((i == 1) ? {1'b1, two[78:0]} : two));
            ent_wr(3'h1, one);
            wr(REG_TAG, 32'h000000FC);
            if (i == 2) begin
                run(16'hD9F9, LOGP1_CLKS);
            end else begin
                run(16'hD9F1, LOG_CLKS);
            end
            rd(REG_STAT, q);
            if (i == 1) begin
                `CHK(q[13], 1'b1)
            end else begin
                `CHK({q[8], q[3:1]}, 4'h9)
            end
            // one times log2 of two is exactly one, left as the new top
            if (i == 0) begin
                ent_chk(3'h0, one);
            end
        end
        restart();
        ent_wr(3'h0, two);
        ent_wr(3'h1, one);
        wr(REG_TAG, 32'h000000FC);
        wr(REG_CMD, 32'h0000D9F1);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (30) @(posedge ref_clk);
        rd(REG_IRQ_STAT, q);
        `CHK(q[3:0], 4'h8)
        rd(REG_STAT, q);
        `CHK(q[3:0], 4'h0)
        ent_chk(3'h1, one);
        $display("test log done");
        summarize();
    end
endmodule
`default_nettype wire
